// ===== src/vim_pkg.sv
// Purpose: Shared constants for the vectored interrupt masking block
// Assumes: One 25 MHz system clock, 32-bit register words
// Notes:   Sources 2..21 are peripheral lines, 1 is programmed, 0 is fast-OR
package vim_pkg;

  localparam int          NSRC         = 22;            // Sources, bit 0 to 21
  localparam int          NPRI         = 8;             // Priority levels 0..7
  localparam logic [31:0] CLK_HZ       = 32'h017d7840;  // System clock rate

  // Normal-request register set
  localparam logic [31:0] OFF_NSTAT    = 32'hffff0000;  // normal_status
  localparam logic [31:0] OFF_NRAW     = 32'hffff0004;  // normal_raw_signal
  localparam logic [31:0] OFF_NEN      = 32'hffff0008;  // normal_enable
  localparam logic [31:0] OFF_NCLR     = 32'hffff000c;  // normal_enable_clear
  localparam logic [31:0] OFF_PROG     = 32'hffff0010;  // programmed_interrupt_cfg
  localparam logic [31:0] OFF_VBASE    = 32'hffff0014;  // vector_base
  localparam logic [31:0] OFF_VEC      = 32'hffff001c;  // active_vector
  localparam logic [31:0] OFF_PRI0     = 32'hffff0020;  // priority_bank_zero
  localparam logic [31:0] OFF_PRI1     = 32'hffff0024;  // Priority bank one
  localparam logic [31:0] OFF_PRI2     = 32'hffff0028;  // Priority bank two
  localparam logic [31:0] OFF_NCTL     = 32'hffff0030;  // nesting_control
  localparam logic [31:0] OFF_NSTN     = 32'hffff0034;  // nesting_status
  // Fast-request register set
  localparam logic [31:0] OFF_FSTAT    = 32'hffff0100;  // fast_status
  localparam logic [31:0] OFF_FRAW     = 32'hffff0104;  // fast_raw_signal
  localparam logic [31:0] OFF_FEN      = 32'hffff0108;  // fast_enable
  localparam logic [31:0] OFF_FCLR     = 32'hffff010c;  // fast_enable_clear

  // Field positions
  localparam int          PROG_NORMAL  = 1;             // Programmed normal bit
  localparam int          PROG_FAST    = 2;             // Programmed fast bit
  localparam int          SRC_PROG     = 1;             // Programmed source slot
  localparam int          NCTL_NORMAL  = 0;             // normal_nesting_en
  localparam int          NCTL_FAST    = 1;             // fast_nesting_en
  localparam int          VEC_SRC_LSB  = 2;             // Source field of vector
  localparam int          VEC_BASE_LSB = 7;             // Base field of vector

  // Reset values
  localparam logic [31:0] RST_WORD     = 32'h00000000;  // All registers
  localparam logic [2:0]  RST_PRI      = 3'h0;          // Priority fields

  // Bus address to priority bank, or 3 when not a bank
  function automatic logic [1:0] bank_of(input logic [31:0] addr);
    bank_of = (addr == OFF_PRI0) ? 2'h0 :
              (addr == OFF_PRI1) ? 2'h1 :
              (addr == OFF_PRI2) ? 2'h2 : 2'h3;
  endfunction : bank_of

  // Source number to bank and nibble slot of its priority field
  function automatic logic [4:0] slot_of(input int src);
    if (src < 8)
      slot_of = {2'h0, 3'(src)};
    else if (src < 16)
      slot_of = {2'h1, 3'(src - 8)};
    else
      slot_of = {2'h2, 3'(src - 16)};
  endfunction : slot_of

endpackage : vim_pkg

// ===== src/vim_if.sv
// Purpose: Carrier between the interrupt controller and the processor core
// Assumes: All signals synchronous to the system clock
// Notes:   Bus is a simple one-cycle strobe bus, read data one cycle later
`timescale 1ns/1ns
interface vim_if;
  logic [31:0] addr;       // Register byte address
  logic        wr_en;      // Write strobe, one cycle
  logic        rd_en;      // Read strobe, one cycle
  logic [31:0] wdata;      // Write data
  logic [31:0] rdata;      // Read data
  logic        rd_valid;   // Read data valid pulse
  logic        fast_line;  // Fast exception request to core
  logic        norm_line;  // Normal exception request to core

  // Controller end
  modport ctrl (input addr, wr_en, rd_en, wdata,
                output rdata, rd_valid, fast_line, norm_line);
  // Core end
  modport core (output addr, wr_en, rd_en, wdata,
                input rdata, rd_valid, fast_line, norm_line);
endinterface : vim_if

// ===== src/vim_ctrl.sv
// Purpose: Interrupt controller with masks, programmed interrupts, vectoring
// Assumes: Source lines are levels synchronous to I_CLK_SYS
// Notes:   Priority 0 is the most urgent level
// Function
// RULE1 - Clear register drops written-one normal enables
// RULE2 - Fast status OR drives line and bit0
// RULE3 - Fast enable write clears matching normal enable
// RULE4 - Normal enable write clears matching fast enable
// RULE5 - Source may be disabled in both masks
// RULE6 - Raw bits follow peripheral request, read-only
// RULE7 - Fast enable gates; writing zero keeps enables
// RULE8 - Fast status is raw AND enable
// RULE9 - Non-vectored mode: no hardware priority encoding
// RULE10 - Software clears fast enable only when safe
// RULE11 - Software never clears pending source enable
// RULE12 - Programmed bit2 drives fast bit1 unmasked
// RULE13 - Programmed bit1 drives normal bit1 unmasked
// RULE14 - Sources hold requests past minimum latency
// RULE15 - Nesting control bits enable vectored handling; here only normal_nesting_en has an effect, fast_nesting_en is stored only
// RULE16 - Eight nesting levels per request type; here only normal requests nest, fast requests have no levels
// RULE17 - Each source takes priority zero to seven
// RULE18 - Vector base holds sixteen bits, upper zero
// RULE19 - Vector packs base, source number, zeros
// RULE20 - Software reads vector only when nesting
// RULE21 - One shared source bit map everywhere
// RULE22 - All normal status bits ORed to line
// RULE23 - Vector read sets nesting bit, blocks lower
// RULE24 - Equal priority ties go to lowest source
`timescale 1ns/1ns
module vim_ctrl (
  input  wire logic        I_CLK_SYS,   // System clock, 25 MHz
  input  wire logic        I_RST,       // Asynchronous reset, active high
  input  wire logic [21:2] I_SRC_REQ,   // Peripheral interrupt levels
  vim_if.ctrl              bus          // Core side
);

  logic [21:0] raw_src;        // Sampled peripheral lines
  logic [21:0] norm_en;        // normal_enable mask
  logic [21:0] fast_en;        // fast_enable mask
  logic [2:1]  prog_cfg;       // programmed_interrupt_cfg bits
  logic [15:0] vec_base;       // vector_base value
  logic [1:0]  nest_ctl;       // nesting_control bits
  logic [7:0]  nest_stat;      // nesting_status, one bit per level
  logic [2:0]  pri [22];       // Priority per source
  logic [21:0] norm_raw;       // normal_raw_signal view
  logic [21:0] fast_raw;       // fast_raw_signal view
  logic [21:0] norm_stat;      // normal_status view
  logic [21:0] fast_stat;      // fast_status view
  logic        fast_or;        // OR of fast status 21..1
  logic [21:0] eligible;       // Normal requests not blocked by nesting
  logic [4:0]  best_src;       // Highest-priority active normal source
  logic        best_ok;        // Some eligible source exists
  logic [31:0] vec_word;       // active_vector view
  logic [31:0] next_rdata;     // Read mux output
  localparam int VB_HI = vim_pkg::VEC_BASE_LSB + 15;        // Top of base field

  // Blocking level: lowest set nesting bit; that level and below are held off
  function automatic logic blocked(input logic [2:0] p, input logic [7:0] ns);
    logic b;
    b = 1'b0;
    for (int k = 0; k < vim_pkg::NPRI; k++)
      if (ns[k] && (3'(k) <= p))
        b = 1'b1;
    blocked = b;
  endfunction : blocked

  // Pack the three priority banks into bus words
  function automatic logic [31:0] bank_word(input logic [1:0] bank,
                                            input logic [2:0] pr [22]);
    logic [31:0] w;
    logic [4:0]  s;
    w = 32'h00000000;
    for (int i = vim_pkg::SRC_PROG; i < vim_pkg::NSRC; i++)
    begin
      s = vim_pkg::slot_of(i);
      if (s[4:3] == bank)
        w[4*s[2:0] +: 3] = pr[i];                           // RULE17
    end
    bank_word = w;
  endfunction : bank_word

  // Sample peripheral lines; the raw bits follow them level for level
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      raw_src <= 22'h000000;
    else
      raw_src <= {I_SRC_REQ, 2'b00};                        // RULE6 RULE14
  end

  // Raw and status views share one bit map; bit 0 carries the fast OR
  always_comb
  begin
    fast_raw = raw_src;                                     // RULE21
    norm_raw = raw_src;
    fast_raw[vim_pkg::SRC_PROG] = prog_cfg[vim_pkg::PROG_FAST];   // RULE12
    norm_raw[vim_pkg::SRC_PROG] = prog_cfg[vim_pkg::PROG_NORMAL]; // RULE13
    fast_stat = fast_raw & fast_en;                         // RULE8 RULE7
    // Programmed interrupts bypass the masks
    fast_stat[vim_pkg::SRC_PROG] = prog_cfg[vim_pkg::PROG_FAST];  // RULE12
    fast_or = |fast_stat[21:1];                             // RULE2
    fast_stat[0] = fast_or;                                 // RULE2
    fast_raw[0] = fast_or;                                  // RULE2
    norm_raw[0] = fast_or;                                  // RULE2
    norm_stat = norm_raw & norm_en;
    norm_stat[vim_pkg::SRC_PROG] = prog_cfg[vim_pkg::PROG_NORMAL]; // RULE13
  end

  // Highest-priority eligible normal source; strict < keeps lowest number
  always_comb
  begin
    best_src = 5'h00;
    best_ok  = 1'b0;
    eligible = 22'h000000;
    for (int i = 0; i < vim_pkg::NSRC; i++)
    begin
      eligible[i] = norm_stat[i] && !blocked(pri[i], nest_stat);   // RULE23
      if (eligible[i] && (!best_ok || (pri[i] < pri[best_src])))   // RULE24
      begin
        best_src = 5'(i);                                   // RULE16
        best_ok  = 1'b1;
      end
    end
    vec_word = 32'h00000000;                                // RULE19
    vec_word[VB_HI:vim_pkg::VEC_BASE_LSB] = vec_base;       // RULE19
    vec_word[6:vim_pkg::VEC_SRC_LSB]      = best_src;       // RULE19
  end

  // Enable masks: set through enable, drop through clear, never both on
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      norm_en <= 22'h000000;
      fast_en <= 22'h000000;
    end
    else if (bus.wr_en)
    begin
      case (bus.addr)
        vim_pkg::OFF_NEN:
        begin
          norm_en <= norm_en | bus.wdata[21:0];             // RULE7
          fast_en <= fast_en & ~bus.wdata[21:0];            // RULE4
        end
        vim_pkg::OFF_FEN:
        begin
          fast_en <= fast_en | bus.wdata[21:0];             // RULE7
          norm_en <= norm_en & ~bus.wdata[21:0];            // RULE3
        end
        vim_pkg::OFF_NCLR: norm_en <= norm_en & ~bus.wdata[21:0];  // RULE1 RULE5
        vim_pkg::OFF_FCLR: fast_en <= fast_en & ~bus.wdata[21:0];  // RULE5
        default: ;                                          // Other registers
      endcase
    end
  end

  // Plain configuration registers
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      prog_cfg <= 2'h0;
      vec_base <= 16'h0000;
      nest_ctl <= 2'h0;
    end
    else if (bus.wr_en)
    begin
      case (bus.addr)
        vim_pkg::OFF_PROG:  prog_cfg <= bus.wdata[2:1];     // RULE12 RULE13
        vim_pkg::OFF_VBASE: vec_base <= bus.wdata[15:0];    // RULE18
        vim_pkg::OFF_NCTL:  nest_ctl <= bus.wdata[1:0];     // RULE15
        default: ;                                          // Not ours
      endcase
    end
  end

  // Priority fields, one 3-bit field per source 1..21
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < vim_pkg::NSRC; i++)
        pri[i] <= vim_pkg::RST_PRI;
    end
    else if (bus.wr_en && (vim_pkg::bank_of(bus.addr) != 2'h3))
    begin
      for (int i = vim_pkg::SRC_PROG; i < vim_pkg::NSRC; i++)
        if (vim_pkg::slot_of(i) >> 3 == 5'(vim_pkg::bank_of(bus.addr)))
          pri[i] <= bus.wdata[4*int'(vim_pkg::slot_of(i) & 5'h07) +: 3]; // RULE17
    end
  end

  // Nesting status: a vector read latches the serviced level; the set
  // wins over a same-cycle software clear so no level is lost
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      nest_stat <= 8'h00;
    else
    begin
      logic [7:0] clr_mask;
      logic [7:0] set_mask;
      clr_mask = 8'h00;
      set_mask = 8'h00;
      if (bus.wr_en && bus.addr == vim_pkg::OFF_NSTN)
        clr_mask = bus.wdata[7:0];                          // Write one to clear
      if (bus.rd_en && bus.addr == vim_pkg::OFF_VEC
          && nest_ctl[vim_pkg::NCTL_NORMAL] && best_ok)
        set_mask[pri[best_src]] = 1'b1;                     // RULE23
      nest_stat <= (nest_stat & ~clr_mask) | set_mask;
    end
  end

  // Exception lines; fast is always a plain OR, normal is a plain OR without nesting, gated by levels with it
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      bus.fast_line <= 1'b0;
      bus.norm_line <= 1'b0;
    end
    else
    begin
      bus.fast_line <= fast_or;                             // RULE2
      if (nest_ctl[vim_pkg::NCTL_NORMAL])
        bus.norm_line <= |eligible;                         // RULE23
      else
        bus.norm_line <= |norm_stat;                        // RULE22 RULE9
    end
  end

  // Read mux; write-only and unmapped addresses read zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    case (bus.addr)
      vim_pkg::OFF_NSTAT: next_rdata[21:0] = norm_stat;
      vim_pkg::OFF_NRAW:  next_rdata[21:0] = norm_raw;      // RULE6
      vim_pkg::OFF_NEN:   next_rdata[21:0] = norm_en;
      vim_pkg::OFF_PROG:  next_rdata[2:1]  = prog_cfg;
      vim_pkg::OFF_VBASE: next_rdata[15:0] = vec_base;      // RULE18
      vim_pkg::OFF_VEC:   next_rdata       = vec_word;      // RULE19 RULE20
      vim_pkg::OFF_PRI0:  next_rdata       = bank_word(2'h0, pri);
      vim_pkg::OFF_PRI1:  next_rdata       = bank_word(2'h1, pri);
      vim_pkg::OFF_PRI2:  next_rdata       = bank_word(2'h2, pri);
      vim_pkg::OFF_NCTL:  next_rdata[1:0]  = nest_ctl;      // RULE15
      vim_pkg::OFF_NSTN:  next_rdata[7:0]  = nest_stat;
      vim_pkg::OFF_FSTAT: next_rdata[21:0] = fast_stat;     // RULE8
      vim_pkg::OFF_FRAW:  next_rdata[21:0] = fast_raw;      // RULE6
      vim_pkg::OFF_FEN:   next_rdata[21:0] = fast_en;
      default:            next_rdata       = 32'h00000000;  // Unmapped or write-only
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      bus.rdata    <= vim_pkg::RST_WORD;
      bus.rd_valid <= 1'b0;
    end
    else
    begin
      bus.rd_valid <= bus.rd_en;
      if (bus.rd_en)
        bus.rdata <= next_rdata;
    end
  end

endmodule : vim_ctrl

// ===== src/vim_core.sv
// Purpose: Core-side end: register commands onto the bus, exceptions out
// Assumes: One command at a time; reads wait for their answer
// Notes:   Commands arriving while a read is open are ignored
`timescale 1ns/1ns
module vim_core (
  input  wire logic        I_CLK_SYS,    // System clock, 25 MHz
  input  wire logic        I_RST,        // Asynchronous reset, active high
  input  wire logic        I_CMD_WR,     // Write command pulse
  input  wire logic        I_CMD_RD,     // Read command pulse
  input  wire logic [31:0] I_CMD_ADDR,   // Register byte address
  input  wire logic [31:0] I_CMD_WDATA,  // Write data
  output      logic [31:0] O_CMD_RDATA,  // Read result
  output      logic        O_CMD_DONE,   // Command finished pulse
  output      logic        O_BUSY,       // Read outstanding
  output      logic        O_FAST_EXC,   // Fast exception request
  output      logic        O_NORM_EXC,   // Normal exception request
  vim_if.core              bus           // Controller side
);

  logic rd_open;   // Read awaiting answer

  // Drive one-cycle strobes; write wins if both commands arrive together
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      bus.addr  <= 32'h00000000;
      bus.wdata <= 32'h00000000;
      bus.wr_en <= 1'b0;
      bus.rd_en <= 1'b0;
    end
    else
    begin
      bus.wr_en <= I_CMD_WR && !rd_open;
      bus.rd_en <= I_CMD_RD && !I_CMD_WR && !rd_open;
      if ((I_CMD_WR || I_CMD_RD) && !rd_open)
      begin
        bus.addr  <= I_CMD_ADDR;
        bus.wdata <= I_CMD_WDATA;
      end
    end
  end

  // Track the open read and report completion
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      rd_open     <= 1'b0;
      O_BUSY      <= 1'b0;
      O_CMD_DONE  <= 1'b0;
      O_CMD_RDATA <= 32'h00000000;
    end
    else
    begin
      O_CMD_DONE <= bus.wr_en || bus.rd_valid;
      if (bus.rd_valid)
        O_CMD_RDATA <= bus.rdata;
      if (I_CMD_RD && !I_CMD_WR && !rd_open)
        rd_open <= 1'b1;
      else if (bus.rd_valid)
        rd_open <= 1'b0;
      O_BUSY <= (I_CMD_RD && !I_CMD_WR && !rd_open) || (rd_open && !bus.rd_valid);
    end
  end

  // Exception requests, retimed for the core
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_FAST_EXC <= 1'b0;
      O_NORM_EXC <= 1'b0;
    end
    else
    begin
      O_FAST_EXC <= bus.fast_line;
      O_NORM_EXC <= bus.norm_line;
    end
  end

endmodule : vim_core

// ===== tb/vim_assertions.sv
// Purpose: Bus-level checks on the carrier between controller and core
// Assumes: One clock domain, reset asynchronous and active high
// Notes:   Shadow masks mirror register writes seen on the bus
`timescale 1ns/1ns
module vim_assertions (
  input  wire logic        I_CLK_SYS,  // System clock
  input  wire logic        I_RST,      // Reset, active high
  input  wire logic [31:0] addr,       // Register address
  input  wire logic        wr_en,      // Write strobe
  input  wire logic        rd_en,      // Read strobe
  input  wire logic [31:0] wdata,      // Write data
  input  wire logic [31:0] rdata,      // Read data
  input  wire logic        rd_valid,   // Read answer pulse
  input  wire logic        fast_line,  // Fast request line
  input  wire logic        norm_line   // Normal request line
);
  logic [21:2] nen;    // Shadow normal mask
  logic [21:2] fen;    // Shadow fast mask
  logic        pn;     // Shadow programmed normal bit
  logic        pf;     // Shadow programmed fast bit
  logic        nest;   // Shadow normal nesting enable
  logic        quiet;  // Nothing able to raise fast

  assign quiet = (fen == 20'h0) && !pf;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  // Normal mask: own write sets, fast write and clear drop
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
    if (I_RST)
      nen <= 20'h0;
    else if (wr_en && addr == vim_pkg::OFF_NEN)
      nen <= nen | wdata[21:2];
    else if (wr_en && (addr == vim_pkg::OFF_FEN || addr == vim_pkg::OFF_NCLR))
      nen <= nen & ~wdata[21:2];

  // Fast mask, mirror image of the normal one
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
    if (I_RST)
      fen <= 20'h0;
    else if (wr_en && addr == vim_pkg::OFF_FEN)
      fen <= fen | wdata[21:2];
    else if (wr_en && (addr == vim_pkg::OFF_NEN || addr == vim_pkg::OFF_FCLR))
      fen <= fen & ~wdata[21:2];

  // Programmed bits and nesting enable
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
    if (I_RST)
      {nest, pf, pn} <= 3'h0;
    else if (wr_en && addr == vim_pkg::OFF_PROG)
      {pf, pn} <= wdata[2:1];
    else if (wr_en && addr == vim_pkg::OFF_NCTL)
      nest <= wdata[0];

  // Three quiet cycles let the line flop drain
  sequence s_fast_quiet;
    quiet [*3];
  endsequence

  // Nesting off so no level can block the request
  sequence s_prog_norm_up;
    $rose(pn) && !nest;
  endsequence

  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read strobe without answer");
  a_valid_cause: assert property (rd_valid |-> $past(rd_en))
    else $error("read answer without strobe");
  a_rdata_holds: assert property (!rd_valid |-> $stable(rdata))
    else $error("read data moved outside an answer");
  a_base_upper_zero: assert property (rd_en && addr == vim_pkg::OFF_VBASE |=>
    rdata[31:16] == 16'h0) else $error("vector base upper half not zero");
  a_vector_fields: assert property (rd_en && addr == vim_pkg::OFF_VEC |=>
    rdata[31:23] == 9'h0 && rdata[1:0] == 2'h0 && rdata[6:2] <= 5'h15)
    else $error("vector word field out of range");
  a_clear_reads_zero: assert property (rd_en &&
    (addr == vim_pkg::OFF_NCLR || addr == vim_pkg::OFF_FCLR) |=> rdata == 32'h0)
    else $error("write-only register read nonzero");
  a_fast_masked: assert property (rd_en && addr == vim_pkg::OFF_FSTAT |=>
    (rdata[21:2] & ~$past(fen)) == 20'h0 && rdata[0] == |rdata[21:1])
    else $error("fast status escapes its mask");
  a_norm_masked: assert property (rd_en && addr == vim_pkg::OFF_NSTAT |=>
    (rdata[21:2] & ~$past(nen)) == 20'h0) else $error("normal status escapes mask");
  a_norm_mask_exact: assert property (rd_en && addr == vim_pkg::OFF_NEN |=>
    rdata[21:2] == $past(nen)) else $error("normal mask differs from writes");
  a_fast_mask_exact: assert property (rd_en && addr == vim_pkg::OFF_FEN |=>
    rdata[21:2] == $past(fen)) else $error("fast mask differs from writes");
  a_fast_quiet: assert property (s_fast_quiet |-> !fast_line)
    else $error("fast line high with nothing enabled");
  a_prog_fast_up: assert property ($rose(pf) |-> ##[1:3] fast_line)
    else $error("programmed fast bit did not raise line");
  a_prog_norm_up: assert property (s_prog_norm_up |-> ##[1:3] norm_line)
    else $error("programmed normal bit did not raise line");
endmodule : vim_assertions

// ===== tb/tb.sv
// Purpose: Self-checking bench for both ends joined by the carrier
// Assumes: 25 MHz clock, commands driven 2 ns after the rising edge
// Notes:   Row table first, then vectoring, back-to-back and reset cases
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [31:0] wa;   // Write address, zero skips
    logic [31:0] wd;   // Write data
    logic [31:0] src;  // Source levels as a word
    logic [31:0] ra;   // Read address
    logic [31:0] exp;  // Expected read data
    logic [1:0]  exc;  // Expected fast, normal
  } vim_row_type;

  logic        clk;                 // System clock
  logic        rst       = 1'b1;    // Reset
  logic        cmd_wr    = 1'b0;    // Write command
  logic        cmd_rd    = 1'b0;    // Read command
  logic [31:0] cmd_addr  = 32'h0;   // Command address
  logic [31:0] cmd_wdata = 32'h0;   // Command data
  logic [21:2] src       = 20'h0;   // Peripheral levels
  logic [31:0] rdata;               // Read result
  logic        done;                // Command done
  logic        fexc;                // Fast exception
  logic        nexc;                // Normal exception
  logic        busy;                // Read open
  int          num_errors = 0;      // Mismatch count
  int          n_checks   = 0;      // Comparison count

  // Cumulative rows, each on the previous state
  vim_row_type rows [22] = '{
    '{vim_pkg::OFF_NEN,   32'hc,        32'hc,  vim_pkg::OFF_NSTAT, 32'hc,    2'h1},
    '{vim_pkg::OFF_FEN,   32'h8,        32'hc,  vim_pkg::OFF_FSTAT, 32'h9,    2'h3},
    '{32'h0,              32'h0,        32'hc,  vim_pkg::OFF_NEN,   32'h4,    2'h3},
    '{vim_pkg::OFF_NSTAT, 32'hffffffff, 32'hc,  vim_pkg::OFF_NSTAT, 32'h4,    2'h3},
    '{vim_pkg::OFF_NEN,   32'h8,        32'hc,  vim_pkg::OFF_FEN,   32'h0,    2'h1},
    '{vim_pkg::OFF_NCLR,  32'h4,        32'h8,  vim_pkg::OFF_NEN,   32'h8,    2'h1},
    '{vim_pkg::OFF_NCLR,  32'h8,        32'h0,  vim_pkg::OFF_NSTAT, 32'h0,    2'h0},
    '{vim_pkg::OFF_FEN,   32'h10,       32'hc,  vim_pkg::OFF_FEN,   32'h10,   2'h0},
    '{vim_pkg::OFF_FEN,   32'h0,        32'h10, vim_pkg::OFF_FSTAT, 32'h11,   2'h2},
    '{32'h0,              32'h0,        32'h10, vim_pkg::OFF_FRAW,  32'h11,   2'h2},
    '{32'h0,              32'h0,        32'h10, vim_pkg::OFF_NRAW,  32'h11,   2'h2},
    '{vim_pkg::OFF_FCLR,  32'h10,       32'h0,  vim_pkg::OFF_FSTAT, 32'h0,    2'h0},
    '{32'h0,              32'h0,        32'h0,  vim_pkg::OFF_FRAW,  32'h0,    2'h0},
    '{vim_pkg::OFF_PROG,  32'h4,        32'h0,  vim_pkg::OFF_FSTAT, 32'h3,    2'h2},
    '{32'h0,              32'h0,        32'h0,  vim_pkg::OFF_FRAW,  32'h3,    2'h2},
    '{vim_pkg::OFF_PROG,  32'h2,        32'h0,  vim_pkg::OFF_NSTAT, 32'h2,    2'h1},
    '{32'h0,              32'h0,        32'h0,  vim_pkg::OFF_NRAW,  32'h2,    2'h1},
    '{vim_pkg::OFF_VBASE, 32'hffff1234, 32'h0,  vim_pkg::OFF_VBASE, 32'h1234, 2'h1},
    '{32'h0,              32'h0,        32'h0,  vim_pkg::OFF_NCLR,  32'h0,    2'h1},
    '{32'h0,              32'h0,        32'h0,  vim_pkg::OFF_FCLR,  32'h0,    2'h1},
    '{vim_pkg::OFF_PROG,  32'h0,        32'h0,  vim_pkg::OFF_NSTAT, 32'h0,    2'h0},
    '{vim_pkg::OFF_PRI2,  32'hffffffff, 32'h0,  vim_pkg::OFF_PRI2,  32'h777777, 2'h0}};
  // Registers that a reset must bring back to zero
  logic [31:0] radr [8] = '{vim_pkg::OFF_NSTAT, vim_pkg::OFF_NEN, vim_pkg::OFF_FEN,
    vim_pkg::OFF_FSTAT, vim_pkg::OFF_VBASE, vim_pkg::OFF_NCTL, vim_pkg::OFF_PRI0,
    vim_pkg::OFF_NSTN};

  vim_if vif ();
  vim_ctrl vim_ctrl_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_SRC_REQ(src), .bus(vif.ctrl));
  vim_core vim_core_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_CMD_WR(cmd_wr), .I_CMD_RD(cmd_rd),
    .I_CMD_ADDR(cmd_addr), .I_CMD_WDATA(cmd_wdata), .O_CMD_RDATA(rdata), .O_CMD_DONE(done),
    .O_BUSY(busy), .O_FAST_EXC(fexc), .O_NORM_EXC(nexc), .bus(vif.core));
  vim_assertions vim_assertions_inst (.I_CLK_SYS(clk), .I_RST(rst), .addr(vif.addr),
    .wr_en(vif.wr_en), .rd_en(vif.rd_en), .wdata(vif.wdata), .rdata(vif.rdata),
    .rd_valid(vif.rd_valid), .fast_line(vif.fast_line), .norm_line(vif.norm_line));

  // Free-running clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One command pulse, then a bounded wait for its done pulse
  task automatic cmd(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    #2;
    cmd_wr = w;
    cmd_rd = !w;
    cmd_addr = a;
    cmd_wdata = d;
    @(posedge clk);
    #2;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    chk({31'h0, busy}, {31'h0, !w});
    for (k = 0; k < 20 && done !== 1'b1; k++)
    begin
      @(posedge clk);
      #2;
    end
    chk({31'h0, done}, 32'h1);
  endtask : cmd

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    cmd(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd_chk

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Watchdog, well past the run
  initial
  begin
    #(40 * 4000);
    num_errors++;
    $display("Watchdog expired");
    give_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    foreach (rows[i])
    begin
      src = rows[i].src[21:2];
      if (rows[i].wa !== 32'h0)
        cmd(1'b1, rows[i].wa, rows[i].wd);
      rd_chk(rows[i].ra, rows[i].exp);
      chk({30'h0, fexc, nexc}, {30'h0, rows[i].exc});
    end
    $display("Row table done");
    // Ties at level 1 between sources 3 and 4, source 2 at level 7
    cmd(1'b1, vim_pkg::OFF_NEN, 32'h1c);
    cmd(1'b1, vim_pkg::OFF_PRI0, 32'h00011700);
    src = 20'h7;
    cmd(1'b1, vim_pkg::OFF_NCTL, 32'h1);
    rd_chk(vim_pkg::OFF_PRI0, 32'h00011700);
    rd_chk(vim_pkg::OFF_VEC, 32'h00091a0c);
    rd_chk(vim_pkg::OFF_NSTN, 32'h2);
    chk({31'h0, nexc}, 32'h0);
    cmd(1'b1, vim_pkg::OFF_NSTN, 32'h2);
    rd_chk(vim_pkg::OFF_NSTN, 32'h0);
    chk({31'h0, nexc}, 32'h1);
    cmd(1'b1, vim_pkg::OFF_NCTL, 32'h0);
    $display("Vectoring done");
    // Two writes on consecutive edges, second undoes the first
    @(posedge clk);
    #2;
    cmd_wr = 1'b1;
    cmd_addr = vim_pkg::OFF_NEN;
    cmd_wdata = 32'h20;
    @(posedge clk);
    #2;
    cmd_addr = vim_pkg::OFF_FEN;
    @(posedge clk);
    #2;
    cmd_wr = 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(vim_pkg::OFF_NEN, 32'h1c);
    rd_chk(vim_pkg::OFF_FEN, 32'h20);
    $display("Back-to-back done");
    // Reset in mid-run must clear every register listed in radr
    src = 20'h0;
    @(posedge clk);
    #2;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    rst = 1'b0;
    foreach (radr[j])
      rd_chk(radr[j], 32'h0);
    chk({30'h0, fexc, nexc}, 32'h0);
    $display("Reset done");
    give_verdict();
  end
endmodule : tb
